/* bmb_consts.svh */
// constants for the block move, branch and call execution unit
`ifndef BMB_CONSTS_SVH
`define BMB_CONSTS_SVH
`define BMB_AW          12
`define BMB_MEM_AW      6
`define BMB_MEM_WORDS   64
`define BMB_STK_DEPTH   8
`define BMB_NUM_AR      8
`define BMB_SEL_REGS    4'h0
`define BMB_SEL_DMEM    4'h1
`define BMB_SEL_PMEM    4'h2
`define BMB_REG_CTRL    8'h00
`define BMB_REG_OPA     8'h04
`define BMB_REG_OPB     8'h08
`define BMB_REG_ACC     8'h0c
`define BMB_REG_STAT    8'h10
`define BMB_REG_PC      8'h14
`define BMB_REG_REPEAT_COUNTER    8'h18
`define BMB_REG_ARP     8'h1c
`define BMB_REG_STKTOP  8'h40
`define BMB_AR_WIN      3'h1
`define BMB_CTRL_OP_HI  4
`define BMB_CTRL_REP    8
`define BMB_CTRL_START  9
`define BMB_STAT_C      0
`define BMB_STAT_OV     1
`define BMB_STAT_BUSY   2
`define BMB_OPB_DMA_HI  5
`define BMB_OPB_IND     8
`define BMB_OPB_MOD_LO  9
`define BMB_OPB_NAR_EN  11
`define BMB_OPB_NAR_LO  12
`define BMB_MOD_NONE    2'h0
`define BMB_MOD_INC     2'h1
`define BMB_MOD_DEC     2'h2
`define BMB_RESP_OKAY   2'h0
`define BMB_RESP_SLVERR 2'h2
`define BMB_STEP_INDIRECT_SUBROUTINE_JUMP   16'h0001
`define BMB_STEP_2WORD  16'h0002
`define BMB_AR_STEP     16'h0001
`define BMB_ZERO16      16'h0000
`define BMB_ZERO32      32'h0000_0000
`endif

/* bmb_pkg.sv */
// types shared by the block move, branch and call execution unit
package bmb_pkg;
  typedef logic [15:0] bmb_word_t;
  // command codes are the enum positions, 0 upward
  typedef enum logic [4:0] {
    BMB_OP_NOP,
    BMB_OP_D2D_COPY_IMM_SRC,
    BMB_OP_D2D_COPY_IMM_DST,
    BMB_OP_DATA_BLOCK_MOVE,
    BMB_OP_P2D_BLOCK_MOVE,
    BMB_OP_P2D_BLOCK_COPY,
    BMB_OP_BR_ACC_NONPOS,
    BMB_OP_BR_ACC_NEG,
    BMB_OP_BR_ACC_ZERO,
    BMB_OP_BR_ACC_NONZERO,
    BMB_OP_BR_NO_CARRY,
    BMB_OP_BR_NO_OVF,
    BMB_OP_BR_OVF,
    BMB_OP_IND_SUB_JUMP,
    BMB_OP_DIRECT_CALL
  } bmb_op_t;
  typedef enum logic {BMB_ST_IDLE, BMB_ST_MOVE} bmb_state_t;
endpackage

/* bmb_aux.sv */
// auxiliary register file with pointer and post-modification
`timescale 1ns/100ps
`include "bmb_consts.svh"
module bmb_aux import bmb_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  wr_be,
  input  wire logic        arp_wr_en,
  input  wire logic [2:0]  arp_wr,
  input  wire logic        mod_en,
  input  wire logic [1:0]  mod_code,
  input  wire logic        nar_en,
  input  wire logic [2:0]  nar,
  input  wire logic [2:0]  rd_idx,
  output logic      [15:0] rd_data,
  output logic      [15:0] cur_ar,
  output logic      [2:0]  aux_pointer
);
  bmb_word_t current_aux_register [`BMB_NUM_AR];
  logic [2:0] arp_r;

  assign cur_ar      = current_aux_register[arp_r];
  assign rd_data     = current_aux_register[rd_idx];
  assign aux_pointer = arp_r;

  // one register per entry; hardware modify wins over a bus write
  for (genvar i = 0; i < `BMB_NUM_AR; i++) begin : g_ar
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        current_aux_register[i] <= `BMB_ZERO16;
      end else if (ce) begin
        if (mod_en && arp_r == 3'(i) && mod_code == `BMB_MOD_INC) begin
          current_aux_register[i] <= current_aux_register[i] + `BMB_AR_STEP;
        end else if (mod_en && arp_r == 3'(i) && mod_code == `BMB_MOD_DEC) begin
          current_aux_register[i] <= current_aux_register[i] - `BMB_AR_STEP;
        end else if (wr_en && wr_idx == 3'(i)) begin
          if (wr_be[0]) current_aux_register[i][7:0] <= wr_data[7:0];
          if (wr_be[1]) current_aux_register[i][15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // pointer reload takes effect after the modify of the old register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arp_r <= 3'h0;
    end else if (ce) begin
      if (nar_en) begin
        arp_r <= nar;
      end else if (arp_wr_en) begin
        arp_r <= arp_wr;
      end
    end
  end
endmodule

/* bmb_stack.sv */
// hardware return-address stack, push only, oldest entry falls off
`timescale 1ns/100ps
`include "bmb_consts.svh"
module bmb_stack import bmb_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  output logic      [15:0] top
);
  bmb_word_t stk [`BMB_STK_DEPTH];

  assign top = stk[0];

  // shift down on push; a full stack silently loses its bottom word
  for (genvar i = 0; i < `BMB_STK_DEPTH; i++) begin : g_stk
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stk[i] <= `BMB_ZERO16;
      end else if (ce && push) begin
        if (i == 0) begin
          stk[i] <= push_data;
        end else begin
          stk[i] <= stk[(i == 0) ? 0 : i - 1];
        end
      end
    end
  end
endmodule

/* bmb_exec.sv */
// block move, conditional branch and call execution unit with axi4-lite access
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "bmb_consts.svh"
module bmb_exec import bmb_pkg::*; (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic [`BMB_AW-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`BMB_AW-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     exec_busy
);
  bmb_word_t  dmem [`BMB_MEM_WORDS];
  bmb_word_t  pmem [`BMB_MEM_WORDS];
  bmb_state_t state_r;
  bmb_op_t    op_r;
  bmb_op_t    cmd_op;
  logic [`BMB_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic        wr_go;
  logic        wr_map;
  logic [3:0]  wsel;
  logic [7:0]  woff;
  logic [31:0] rd_data;
  logic        rd_map;
  logic [31:0] acc_r;
  logic        carry_r;
  logic        ovf_r;
  bmb_word_t   pc_r;
  bmb_word_t   repeat_counter;
  bmb_word_t   opa_r;
  bmb_word_t   opb_r;
  bmb_word_t   imm_r;
  bmb_word_t   cnt_r;
  logic        busy_r;
  logic        start_go;
  logic        is_move;
  logic        is_branch;
  logic        take;
  logic        acc_zero;
  logic        opb_ind;
  logic        mv_step;
  logic        mv_last;
  logic        src_prog;
  logic        imm_dst;
  logic [`BMB_MEM_AW-1:0] side_addr;
  logic [`BMB_MEM_AW-1:0] mv_dst;
  bmb_word_t   mv_data;
  bmb_word_t   cur_ar;
  bmb_word_t   ar_rd;
  bmb_word_t   stk_top;
  logic [2:0]  aux_pointer;
  logic        mod_en;
  logic        nar_en;
  logic        ar_we;
  logic        arp_we;
  logic        push;
  bmb_word_t   push_data;

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      mrg[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  function automatic logic reg_we(input logic go, input logic [3:0] sel, input logic [7:0] off,
                                  input logic [7:0] tgt, input logic busy);
    reg_we = go && sel == `BMB_SEL_REGS && off == tgt && !busy;
  endfunction

  // write decode; aw and w are taken in either order, response after both
  assign wsel  = awaddr_r[`BMB_AW-1:8];
  assign woff  = awaddr_r[7:0];
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_comb begin
    wr_map = 1'b0;
    if (wsel == `BMB_SEL_DMEM || wsel == `BMB_SEL_PMEM) begin
      wr_map = 1'b1;
    end else if (wsel == `BMB_SEL_REGS) begin
      wr_map = woff <= `BMB_REG_ARP || woff[7:5] == `BMB_AR_WIN || woff == `BMB_REG_STKTOP;
    end
  end

  // write address channel held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_hold_r     <= 1'b0;
      awaddr_r      <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_hold_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_hold_r     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end

  // write data channel held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_hold_r     <= 1'b0;
      wdata_r      <= `BMB_ZERO32;
      wstrb_r      <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_hold_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_hold_r     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response; writes while a move runs are dropped, but mapped ones are still answered okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BMB_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `BMB_RESP_OKAY : `BMB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux straight from the live address; answer is registered
  always_comb begin
    rd_data = `BMB_ZERO32;
    rd_map  = 1'b1;
    if (s_axi_araddr[`BMB_AW-1:8] == `BMB_SEL_DMEM) begin
      rd_data = {16'h0000, dmem[s_axi_araddr[`BMB_MEM_AW+1:2]]};
    end else if (s_axi_araddr[`BMB_AW-1:8] == `BMB_SEL_PMEM) begin
      rd_data = {16'h0000, pmem[s_axi_araddr[`BMB_MEM_AW+1:2]]};
    end else if (s_axi_araddr[`BMB_AW-1:8] != `BMB_SEL_REGS) begin
      rd_map = 1'b0;
    end else if (s_axi_araddr[7:5] == `BMB_AR_WIN) begin
      rd_data = {16'h0000, ar_rd};
    end else begin
      case (s_axi_araddr[7:0])
        `BMB_REG_CTRL:   rd_data = {22'h0, busy_r, 4'h0, op_r};
        `BMB_REG_OPA:    rd_data = {16'h0000, opa_r};
        `BMB_REG_OPB:    rd_data = {16'h0000, opb_r};
        `BMB_REG_ACC:    rd_data = acc_r;
        `BMB_REG_STAT:   rd_data = {29'h0, busy_r, ovf_r, carry_r};
        `BMB_REG_PC:     rd_data = {16'h0000, pc_r};
        `BMB_REG_REPEAT_COUNTER:   rd_data = {16'h0000, repeat_counter};
        `BMB_REG_ARP:    rd_data = {29'h0, aux_pointer};
        `BMB_REG_STKTOP: rd_data = {16'h0000, stk_top};
        default:         rd_map  = 1'b0;
      endcase
    end
  end

  // read channel: one read in flight, answer one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `BMB_ZERO32;
      s_axi_rresp   <= `BMB_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_map ? `BMB_RESP_OKAY : `BMB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // command decode; a ctrl write with the start bit launches one instruction
  assign cmd_op    = bmb_op_t'(wdata_r[`BMB_CTRL_OP_HI:0]);
  assign start_go  = reg_we(wr_go, wsel, woff, `BMB_REG_CTRL, busy_r) && wstrb_r[1] &&
                     wdata_r[`BMB_CTRL_START];
  assign is_move   = cmd_op inside {[BMB_OP_D2D_COPY_IMM_SRC:BMB_OP_P2D_BLOCK_COPY]};
  assign is_branch = cmd_op inside {[BMB_OP_BR_ACC_NONPOS:BMB_OP_DIRECT_CALL]};
  assign acc_zero  = acc_r == `BMB_ZERO32;
  assign opb_ind   = opb_r[`BMB_OPB_IND];

  // branch condition from accumulator and status flags
  always_comb begin
    case (cmd_op)
      BMB_OP_BR_ACC_NONPOS:  take = acc_r[31] || acc_zero;
      BMB_OP_BR_ACC_NEG:     take = acc_r[31];
      BMB_OP_BR_ACC_ZERO:    take = acc_zero;
      BMB_OP_BR_ACC_NONZERO: take = !acc_zero;
      BMB_OP_BR_NO_CARRY:    take = !carry_r;
      BMB_OP_BR_NO_OVF:      take = !ovf_r;
      BMB_OP_BR_OVF:         take = ovf_r;
      BMB_OP_IND_SUB_JUMP:   take = 1'b1;
      BMB_OP_DIRECT_CALL:    take = 1'b1;
      default:               take = 1'b0;
    endcase
  end

  // move datapath: immediate side walks, other side is direct or indirect
  assign src_prog  = op_r == BMB_OP_P2D_BLOCK_MOVE || op_r == BMB_OP_P2D_BLOCK_COPY;
  assign imm_dst   = op_r == BMB_OP_D2D_COPY_IMM_DST;
  assign side_addr = opb_ind ? cur_ar[`BMB_MEM_AW-1:0] : opb_r[`BMB_OPB_DMA_HI:0];
  assign mv_step   = state_r == BMB_ST_MOVE;
  assign mv_last   = mv_step && cnt_r == `BMB_ZERO16;
  assign mv_dst    = imm_dst ? imm_r[`BMB_MEM_AW-1:0] : side_addr;
  always_comb begin
    if (src_prog) begin
      mv_data = pmem[imm_r[`BMB_MEM_AW-1:0]];
    // one side immediate, the other a data address
    end else if (imm_dst) begin
      mv_data = dmem[side_addr];
    end else begin
      mv_data = dmem[imm_r[`BMB_MEM_AW-1:0]];
    end
  end

  // sequencer: one word per edge, count loaded once at the start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= BMB_ST_IDLE;
      op_r    <= BMB_OP_NOP;
      cnt_r   <= `BMB_ZERO16;
      imm_r   <= `BMB_ZERO16;
      busy_r  <= 1'b0;
    end else if (ce) begin
      case (state_r)
        BMB_ST_IDLE: begin
          if (start_go) begin
            op_r <= cmd_op;
          end
          if (start_go && is_move) begin
            state_r <= BMB_ST_MOVE;
            busy_r  <= 1'b1;
            cnt_r   <= wdata_r[`BMB_CTRL_REP] ? repeat_counter : `BMB_ZERO16;
            // immediate address is the first source word, or the first destination word for BMB_OP_D2D_COPY_IMM_DST
            imm_r   <= opa_r;
          end
        end
        BMB_ST_MOVE: begin
          imm_r <= imm_r + `BMB_AR_STEP;
          cnt_r <= cnt_r - `BMB_AR_STEP;
          if (mv_last) begin
            state_r <= BMB_ST_IDLE;
            busy_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= BMB_ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // data memory: a running move has priority over the bus
  always_ff @(posedge aclk) begin
    if (ce) begin
      // indirect words land in a contiguous space only with an inc or dec modifier
      if (mv_step) begin
        dmem[mv_dst] <= mv_data;
      end else if (wr_go && wsel == `BMB_SEL_DMEM && !busy_r) begin
        if (wstrb_r[0]) dmem[woff[`BMB_MEM_AW+1:2]][7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) dmem[woff[`BMB_MEM_AW+1:2]][15:8] <= wdata_r[15:8];
      end
    end
  end

  // program memory is only loaded over the bus
  always_ff @(posedge aclk) begin
    if (ce && wr_go && wsel == `BMB_SEL_PMEM && !busy_r) begin
      if (wstrb_r[0]) pmem[woff[`BMB_MEM_AW+1:2]][7:0] <= wdata_r[7:0];
      if (wstrb_r[1]) pmem[woff[`BMB_MEM_AW+1:2]][15:8] <= wdata_r[15:8];
    end
  end

  // operand registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opa_r          <= `BMB_ZERO16;
      opb_r          <= `BMB_ZERO16;
      repeat_counter <= `BMB_ZERO16;
    end else if (ce) begin
      if (reg_we(wr_go, wsel, woff, `BMB_REG_OPA, busy_r)) opa_r <= 16'(mrg({16'h0000, opa_r}, wdata_r, wstrb_r));
      if (reg_we(wr_go, wsel, woff, `BMB_REG_OPB, busy_r)) opb_r <= 16'(mrg({16'h0000, opb_r}, wdata_r, wstrb_r));
      if (reg_we(wr_go, wsel, woff, `BMB_REG_REPEAT_COUNTER, busy_r)) begin
        repeat_counter <= 16'(mrg({16'h0000, repeat_counter}, wdata_r, wstrb_r));
      end
    end
  end

  // accumulator, loaded by software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= `BMB_ZERO32;
    end else if (ce && reg_we(wr_go, wsel, woff, `BMB_REG_ACC, busy_r)) begin
      acc_r <= mrg(acc_r, wdata_r, wstrb_r);
    end
  end

  // status flags; the overflow clear by a taken branch wins over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_r <= 1'b0;
      ovf_r   <= 1'b0;
    end else if (ce) begin
      if (reg_we(wr_go, wsel, woff, `BMB_REG_STAT, busy_r) && wstrb_r[0]) begin
        carry_r <= wdata_r[`BMB_STAT_C];
        ovf_r   <= wdata_r[`BMB_STAT_OV];
      end
      // taken overflow branch clears the flag
      if (start_go && cmd_op == BMB_OP_BR_OVF && ovf_r) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // program counter: taken branch loads target, else skips the two-word branch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= `BMB_ZERO16;
    end else if (ce) begin
      if (start_go && is_branch) begin
        // accumulator low half is the target
        if (cmd_op == BMB_OP_IND_SUB_JUMP) begin
          pc_r <= acc_r[15:0];
        end else if (take) begin
          pc_r <= opa_r;
        end else begin
          pc_r <= pc_r + `BMB_STEP_2WORD;
        end
      end else if (reg_we(wr_go, wsel, woff, `BMB_REG_PC, busy_r)) begin
        pc_r <= 16'(mrg({16'h0000, pc_r}, wdata_r, wstrb_r));
      end
    end
  end

  // return address: one-word call pushes pc+1, two-word call pc+2
  assign push      = start_go && (cmd_op == BMB_OP_IND_SUB_JUMP || cmd_op == BMB_OP_DIRECT_CALL);
  assign push_data = cmd_op == BMB_OP_IND_SUB_JUMP ? pc_r + `BMB_STEP_INDIRECT_SUBROUTINE_JUMP : pc_r + `BMB_STEP_2WORD;

  // aux update on every move step in indirect mode and on modified branches;
  // the indirect call carries no modifier
  // move updates aux register per operand
  assign mod_en = opb_ind && (mv_step || (start_go && is_branch && cmd_op != BMB_OP_IND_SUB_JUMP));
  // pointer reload at any branch but the indirect call, or at the last move step
  assign nar_en = mod_en && opb_r[`BMB_OPB_NAR_EN] && (mv_last || start_go);
  assign ar_we  = wr_go && wsel == `BMB_SEL_REGS && woff[7:5] == `BMB_AR_WIN && !busy_r;
  assign arp_we = reg_we(wr_go, wsel, woff, `BMB_REG_ARP, busy_r) && wstrb_r[0];

  bmb_aux i_bmb_aux (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .wr_en       (ar_we),
    .wr_idx      (woff[4:2]),
    .wr_data     (wdata_r[15:0]),
    .wr_be       (wstrb_r[1:0]),
    .arp_wr_en   (arp_we),
    .arp_wr      (wdata_r[2:0]),
    .mod_en      (mod_en),
    .mod_code    (opb_r[`BMB_OPB_MOD_LO +: 2]),
    .nar_en      (nar_en),
    .nar         (opb_r[`BMB_OPB_NAR_LO +: 3]),
    .rd_idx      (s_axi_araddr[4:2]),
    .rd_data     (ar_rd),
    .cur_ar      (cur_ar),
    .aux_pointer (aux_pointer)
  );

  bmb_stack i_bmb_stack (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .push      (push),
    .push_data (push_data),
    .top       (stk_top)
  );

  assign exec_busy = busy_r;
endmodule

/* bmb_exec_properties.sv */
// bus and busy timing assertions for the execution unit
`timescale 1ns/100ps
module bmb_exec_checker (
  input logic        aclk,
  input logic        aresetn,
  input logic        ce,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        exec_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write answer comes two edges after both halves are taken
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
    |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer timing wrong");
  property p_b_hold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write taken while answer pending");
  property p_b_release; s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write answer not released");
  // read data exactly one edge after the address
  property p_r_answer; s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer timing wrong");
  property p_r_release; s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_r_release: assert property (p_r_release) else $error("read answer not released");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
  property p_rresp_legal; s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}; endproperty
  a_rresp_legal: assert property (p_rresp_legal) else $error("read response code illegal");
  // a move can only start from the control write answer
  property p_busy_start; $rose(exec_busy) |-> $rose(s_axi_bvalid); endproperty
  a_busy_start: assert property (p_busy_start) else $error("move started without a write");
  c_move: cover property ($rose(exec_busy));
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind bmb_exec bmb_exec_checker i_bmb_exec_checker (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy);

/* bmb_mem_model.sv */
// memory image model for the source words of block moves
`timescale 1ns/100ps
module bmb_mem_model;
  // distinct per op and word, so a skipped or repeated word shows
  function automatic logic [15:0] word(input int k, input int j);
    return 16'ha500 + 16'(k * 16 + j);
  endfunction
endmodule

/* tb_bmb_exec.sv */
// self-checking bench for the execution unit
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, e); end end
module tb_bmb_exec;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [11:0] awaddr = 0, araddr = 0, sb;
  logic [31:0] wdata = 0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]  bresp, rresp;
  logic [5:0]  si, di;
  int          miscompares = 0, checks = 0, cyc = 0, nbusy = 0;
  typedef struct packed {logic [4:0] op; logic [31:0] acc; logic [1:0] st; logic [15:0] pc; logic [1:0] est;} bmb_row_t;
  // op, accumulator, status in, pc out, status out
  bmb_row_t    rows [16] = '{'{5'd6, 32'h0, 2'h0, 16'h80, 2'h0}, '{5'd6, 32'h1, 2'h0, 16'h12, 2'h0},
    '{5'd7, 32'hffffffff, 2'h0, 16'h80, 2'h0}, '{5'd7, 32'h0, 2'h0, 16'h12, 2'h0},
    '{5'd8, 32'h0, 2'h0, 16'h80, 2'h0}, '{5'd8, 32'h5, 2'h0, 16'h12, 2'h0},
    '{5'd9, 32'h0, 2'h0, 16'h12, 2'h0}, '{5'd9, 32'hffff0000, 2'h0, 16'h80, 2'h0},
    '{5'd10, 32'h0, 2'h0, 16'h80, 2'h0}, '{5'd10, 32'h0, 2'h1, 16'h12, 2'h1},
    '{5'd11, 32'h0, 2'h1, 16'h80, 2'h1}, '{5'd11, 32'h0, 2'h2, 16'h12, 2'h2},
    '{5'd12, 32'h0, 2'h2, 16'h80, 2'h0}, '{5'd12, 32'h0, 2'h1, 16'h12, 2'h1},
    '{5'd13, 32'hffff1234, 2'h0, 16'h1234, 2'h0}, '{5'd14, 32'h0, 2'h0, 16'h80, 2'h0}};
  logic [4:0]  mops [5] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5};
  bmb_exec i_bmb_exec (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .exec_busy(busy));
  bmb_mem_model i_bmb_mem_model ();
  always #5 aclk = ~aclk;
  // busy cycle count and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) nbusy <= nbusy + 1;
    if (cyc == 6000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bready stays high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    `CHK(bresp, er)
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(busy, 1'b0)
    rc(12'h014, 32'h0);
    // branch and call table, from pc 0x10 to operand 0x80
    foreach (rows[i]) begin
      wr(12'h00c, rows[i].acc);
      wr(12'h010, {30'h0, rows[i].st});
      wr(12'h014, 32'h10);
      wr(12'h004, 32'h80);
      wr(12'h008, 32'h0);
      wr(12'h000, {27'h0, rows[i].op} | 32'h200);
      rc(12'h014, {16'h0, rows[i].pc});
      rc(12'h010, {30'h0, rows[i].est});
      if (rows[i].op > 5'd12) rc(12'h040, rows[i].op == 5'd13 ? 32'h11 : 32'h12);
    end
    // modifier on a taken zero branch, then on a direct call
    wr(12'h01c, 32'h1);
    wr(12'h024, 32'h5);
    wr(12'h008, 32'h2b00);
    wr(12'h000, 32'h208);
    rc(12'h024, 32'h6);
    rc(12'h01c, 32'h2);
    wr(12'h008, 32'h1d00);
    wr(12'h000, 32'h20e);
    rc(12'h028, 32'hffff);
    rc(12'h01c, 32'h1);
    // eight-word repeated moves; a write during the move must be ignored
    foreach (mops[k]) begin
      si = (mops[k] == 5'd2) ? 6'h30 : 6'h20;
      di = (mops[k] == 5'd2) ? 6'h20 : 6'h30;
      sb = (mops[k] > 5'd3) ? 12'h200 : 12'h100;
      for (int j = 0; j < 9; j++) begin
        if (j < 8) wr(sb + 12'(4 * (si + j)), {16'h0, i_bmb_mem_model.word(k, j)});
        wr(12'h100 + 12'(4 * (di + j)), 32'h0);
      end
      wr(12'h01c, 32'h1);
      wr(12'h024, 32'h30);
      wr(12'h018, 32'h7);
      wr(12'h004, 32'h20);
      wr(12'h008, 32'h2b00);
      nbusy = 0;
      wr(12'h000, {27'h0, mops[k]} | 32'h300);
      wr(12'h018, 32'h1);
      while (busy === 1'b1) @(posedge aclk);
      `CHK(nbusy, 8)
      for (int j = 0; j < 9; j++) begin
        rc(12'h100 + 12'(4 * (di + j)),
           j < 8 ? {16'h0, i_bmb_mem_model.word(k, j)} : 32'h0);
      end
      rc(12'h024, 32'h38);
      rc(12'h01c, 32'h2);
      rc(12'h018, 32'h7);
    end
    // one word, direct address, no repeat
    wr(12'h180, 32'h1234);
    wr(12'h008, 32'h5);
    nbusy = 0;
    wr(12'h000, 32'h201);
    while (busy === 1'b1) @(posedge aclk);
    `CHK(nbusy, 1)
    rc(12'h114, 32'h1234);
    // reset in mid-move drops busy and clears the pointer and repeat count
    wr(12'h000, 32'h301);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(busy, 1'b0)
    rc(12'h01c, 32'h0);
    rc(12'h018, 32'h0);
    wr(12'h080, 32'h1, 2'h2);
    rc(12'h080, 32'h0, 2'h2);
    summarize();
  end
endmodule
